// file: verilog/gpio_port_pkg.sv
// package for the remappable general purpose port c: offsets, layouts, resets
// assumes a 32-bit axi4-lite slave sitting on the peripheral bus clock
package gpio_port_pkg;
  // =====================================================
  // widths
  localparam int unsigned ADDR_W = 16;    // byte address width
  localparam int unsigned DATA_W = 32;    // bus data width
  localparam int unsigned PIN_W = 16;     // pins of port c
  localparam int unsigned SEL_W = 4;      // remap selector width
  localparam int unsigned NUM_IN_SEL = 2; // remappable peripheral inputs
  localparam int unsigned NUM_RP = 2;     // remappable output pins
  // =====================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT = 16'h6200;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 16'h6210;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 16'h6220;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 16'h6230;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 16'h6240;
  localparam logic [ADDR_W-1:0] OFS_PULL_UP = 16'h6250;
  localparam logic [ADDR_W-1:0] OFS_PULL_DOWN = 16'h6260;
  localparam logic [ADDR_W-1:0] OFS_CN_CONTROL = 16'h6270;
  localparam logic [ADDR_W-1:0] OFS_CN_ENABLE = 16'h6280;
  localparam logic [ADDR_W-1:0] OFS_CN_STATUS = 16'h6290;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'h62a0;  // interrupt mask
  localparam logic [ADDR_W-1:0] OFS_IN_SEL0 = 16'h62b0;   // peripheral input selector 0
  localparam logic [ADDR_W-1:0] OFS_IN_SEL1 = 16'h62c0;   // peripheral input selector 1
  localparam logic [ADDR_W-1:0] OFS_RP_SEL0 = 16'h62d0;   // output selector pin 0
  localparam logic [ADDR_W-1:0] OFS_RP_SEL1 = 16'h62e0;   // output selector pin 1
  // alias sub-offsets within each 16-byte slot
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // =====================================================
  // implemented bits and reset values
  localparam logic [PIN_W-1:0] PIN_MASK = 16'hf01e;     // pins 15..12, 4..1
  localparam logic [PIN_W-1:0] ANALOG_MASK = 16'h000e;  // pins 3..1
  localparam logic [PIN_W-1:0] ANALOG_RST = 16'h000e;
  localparam logic [PIN_W-1:0] DIRECTION_RST = 16'hffff;
  localparam logic [PIN_W-1:0] CN_CTRL_MASK = 16'ha000; // on and stop_in_idle
  localparam int unsigned CN_ON_BIT = 15;
  localparam int unsigned STOP_IN_IDLE_BIT = 13;
  localparam logic [PIN_W-1:0] ZERO_RST = 16'h0000;
  // =====================================================
  // remap codes
  localparam logic [SEL_W-1:0] IN_SEL_RSV_A = 4'ha;
  localparam logic [SEL_W-1:0] IN_SEL_RSV_E = 4'he;
  localparam logic [SEL_W-1:0] IN_SEL_RSV_F = 4'hf;
  localparam logic [SEL_W-1:0] RP_NO_CONNECT = 4'h0;
  localparam int unsigned NUM_PERIPH_OUT = 16;  // peripheral outputs indexed by code
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/gpio_pin_sync.sv
// two-flop synchroniser for the external pin levels
// assumes pins are asynchronous to the core clock
`timescale 1ns/1ps
module gpio_pin_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // =====================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by second
    logic [WIDTH-1:0] sync; // second stage
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;

  // next state: shift pin sample through two stages
  always_comb begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  // register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;
endmodule

// file: verilog/gpio_port.sv
// port c general purpose i/o with pin remap, axi4-lite register slave
// assumes pads outside resolve drive, pulls and open drain from the controls
//
// Notes on behaviour
// - active remapped peripheral owns the pin
// - per-pin open-drain enable
// - independent weak pull-up and pull-down enables
// - enabled pin change sets status, raises interrupt; here the interrupt is raised only where the irq_mask bit is set
// - port keeps running in sleep and idle
// - clear, set, invert aliases at +4,+8,+c
// - four-bit input selector, codes a,e,f reserved
// - four-bit output selector, zero unconnected
// - latch undefined at reset, unimplemented bits zero
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // axi4-lite slave
  input wire logic [gpio_port_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [gpio_port_pkg::DATA_W-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [gpio_port_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // pins
  input wire logic [gpio_port_pkg::PIN_W-1:0] I_PIN,
  output logic [gpio_port_pkg::PIN_W-1:0] O_PIN,
  output logic [gpio_port_pkg::PIN_W-1:0] O_PIN_OE_N,
  output logic [gpio_port_pkg::PIN_W-1:0] O_OPEN_DRAIN,
  output logic [gpio_port_pkg::PIN_W-1:0] O_PULL_UP,
  output logic [gpio_port_pkg::PIN_W-1:0] O_PULL_DOWN,
  output logic [gpio_port_pkg::PIN_W-1:0] O_ANALOG,
  // peripheral side
  input wire logic [gpio_port_pkg::NUM_PERIPH_OUT-1:0] I_PERIPH_OUT,
  output logic [gpio_port_pkg::NUM_IN_SEL-1:0] O_PERIPH_IN,
  output logic O_IRQ
);
  import gpio_port_pkg::*;

  // =====================================================
  // state
  typedef struct packed {
    logic [PIN_W-1:0] analog;      // analog_select_c
    logic [PIN_W-1:0] direction;   // direction_c
    logic [PIN_W-1:0] latch;       // output_latch_c
    logic [PIN_W-1:0] odc;         // open_drain_c
    logic [PIN_W-1:0] pu;          // pull_up_enable_c
    logic [PIN_W-1:0] pd;          // pull_down_enable_c
    logic [PIN_W-1:0] cn_ctrl;     // change_notice_control_c
    logic [PIN_W-1:0] cn_en;       // change_notice_enable_c
    logic [PIN_W-1:0] cn_stat;     // change_notice_status_c
    logic [PIN_W-1:0] irq_mask;    // interrupt mask
    logic [PIN_W-1:0] last_pin;    // pin level seen last cycle
    logic [NUM_IN_SEL-1:0][SEL_W-1:0] in_sel;
    logic [NUM_RP-1:0][SEL_W-1:0] rp_sel;
    logic aw_hold;                 // write address captured
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;                  // write data captured
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } port_state_t;
  port_state_t s_q;
  port_state_t s_d;

  logic [PIN_W-1:0] pin_sync; // synchronised pin levels

  // pins cross into the core clock through two flops
  gpio_pin_sync #(.WIDTH(PIN_W)) u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_async(I_PIN),
    .o_sync(pin_sync)
  );

  // =====================================================
  // helpers
  // alias update: base replaces, others touch only written ones
  function automatic logic [PIN_W-1:0] alias_upd(input logic [PIN_W-1:0] cur, input logic [PIN_W-1:0] wd,
                                                 input logic [1:0] op, input logic [PIN_W-1:0] msk);
    logic [PIN_W-1:0] r;
    r = cur;
    unique case (op)
      ALIAS_BASE: r = wd;
      ALIAS_CLR: r = cur & ~wd;
      ALIAS_SET: r = cur | wd;
      ALIAS_INV: r = cur ^ wd;
    endcase
    return r & msk; // unimplemented bits stay zero
  endfunction

  logic wr_go;                 // write address and data both present
  logic [ADDR_W-1:0] wr_slot;  // slot base of write
  logic [1:0] wr_op;           // alias selected by write
  logic [PIN_W-1:0] wr_val;    // strobed low half of write data
  logic wr_hit;
  logic [ADDR_W-1:0] rd_slot;
  logic rd_go;
  logic [PIN_W-1:0] rd_val;
  logic rd_hit;
  logic [PIN_W-1:0] change;    // edges on enabled pins
  logic cn_on;

  // =====================================================
  // next state
  always_comb begin
    s_d = s_q;
    // axi channel capture, either order
    if (I_AWVALID && O_AWREADY) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = I_WDATA;
      s_d.w_strb = I_WSTRB;
    end
    wr_go = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    wr_slot = {s_q.aw_addr[ADDR_W-1:4], 4'h0};
    wr_op = s_q.aw_addr[3:2];
    wr_val = {(s_q.w_strb[1] ? s_q.w_data[15:8] : 8'h00), (s_q.w_strb[0] ? s_q.w_data[7:0] : 8'h00)};
    wr_hit = 1'b1;
    // change detect runs every cycle, no low-power gating
    cn_on = s_q.cn_ctrl[CN_ON_BIT];
    change = (pin_sync ^ s_q.last_pin) & s_q.cn_en & PIN_MASK & {PIN_W{cn_on}};
    s_d.last_pin = pin_sync;
    // register write
    if (wr_go) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      unique case (wr_slot)
        OFS_ANALOG_SELECT: s_d.analog = alias_upd(s_q.analog, wr_val, wr_op, ANALOG_MASK);
        OFS_DIRECTION: s_d.direction = alias_upd(s_q.direction, wr_val, wr_op, PIN_MASK);
        // pin level writes go to the latch
        OFS_PIN_LEVEL, OFS_OUTPUT_LATCH: s_d.latch = alias_upd(s_q.latch, wr_val, wr_op, PIN_MASK);
        OFS_OPEN_DRAIN: s_d.odc = alias_upd(s_q.odc, wr_val, wr_op, PIN_MASK);
        OFS_PULL_UP: s_d.pu = alias_upd(s_q.pu, wr_val, wr_op, PIN_MASK);
        OFS_PULL_DOWN: s_d.pd = alias_upd(s_q.pd, wr_val, wr_op, PIN_MASK);
        OFS_CN_CONTROL: s_d.cn_ctrl = alias_upd(s_q.cn_ctrl, wr_val, wr_op, CN_CTRL_MASK);
        OFS_CN_ENABLE: s_d.cn_en = alias_upd(s_q.cn_en, wr_val, wr_op, PIN_MASK);
        OFS_CN_STATUS: ; // read only
        OFS_IRQ_MASK: s_d.irq_mask = alias_upd(s_q.irq_mask, wr_val, wr_op, PIN_MASK);
        OFS_IN_SEL0: s_d.in_sel[0] = SEL_W'(alias_upd({12'h000, s_q.in_sel[0]}, wr_val, wr_op, 16'h000f));
        OFS_IN_SEL1: s_d.in_sel[1] = SEL_W'(alias_upd({12'h000, s_q.in_sel[1]}, wr_val, wr_op, 16'h000f));
        OFS_RP_SEL0: s_d.rp_sel[0] = SEL_W'(alias_upd({12'h000, s_q.rp_sel[0]}, wr_val, wr_op, 16'h000f));
        OFS_RP_SEL1: s_d.rp_sel[1] = SEL_W'(alias_upd({12'h000, s_q.rp_sel[1]}, wr_val, wr_op, 16'h000f));
        default: wr_hit = 1'b0;
      endcase
      s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && I_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    // register read
    rd_go = I_ARVALID && O_ARREADY;
    rd_slot = {I_ARADDR[ADDR_W-1:4], 4'h0};
    rd_hit = 1'b1;
    unique case (rd_slot)
      OFS_ANALOG_SELECT: rd_val = s_q.analog;
      OFS_DIRECTION: rd_val = s_q.direction;
      OFS_PIN_LEVEL: rd_val = pin_sync & PIN_MASK;
      OFS_OUTPUT_LATCH: rd_val = s_q.latch;
      OFS_OPEN_DRAIN: rd_val = s_q.odc;
      OFS_PULL_UP: rd_val = s_q.pu;
      OFS_PULL_DOWN: rd_val = s_q.pd;
      OFS_CN_CONTROL: rd_val = s_q.cn_ctrl;
      OFS_CN_ENABLE: rd_val = s_q.cn_en;
      OFS_CN_STATUS: rd_val = s_q.cn_stat;
      OFS_IRQ_MASK: rd_val = s_q.irq_mask;
      OFS_IN_SEL0: rd_val = {12'h000, s_q.in_sel[0]};
      OFS_IN_SEL1: rd_val = {12'h000, s_q.in_sel[1]};
      OFS_RP_SEL0: rd_val = {12'h000, s_q.rp_sel[0]};
      OFS_RP_SEL1: rd_val = {12'h000, s_q.rp_sel[1]};
      default: begin
        rd_val = ZERO_RST;
        rd_hit = 1'b0;
      end
    endcase
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {16'h0000, rd_val}; // upper half reads zero
      s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && I_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    // status: any read in its slot (base or alias) clears, a new change wins over the clear
    if (rd_go && rd_slot == OFS_CN_STATUS) begin
      s_d.cn_stat = ZERO_RST;
    end
    s_d.cn_stat = s_d.cn_stat | change;
  end

  // register; latch has no reset so it powers up unknown
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q.analog <= ANALOG_RST;
      s_q.direction <= DIRECTION_RST & PIN_MASK;
      s_q.odc <= ZERO_RST;
      s_q.pu <= ZERO_RST;
      s_q.pd <= ZERO_RST;
      s_q.cn_ctrl <= ZERO_RST;
      s_q.cn_en <= ZERO_RST;
      s_q.cn_stat <= ZERO_RST;
      s_q.irq_mask <= ZERO_RST;
      s_q.last_pin <= ZERO_RST;
      s_q.in_sel <= '0;
      s_q.rp_sel <= '0;
      s_q.aw_hold <= 1'b0;
      s_q.aw_addr <= '0;
      s_q.w_hold <= 1'b0;
      s_q.w_data <= '0;
      s_q.w_strb <= '0;
      s_q.bvalid <= 1'b0;
      s_q.bresp <= RESP_OKAY;
      s_q.rvalid <= 1'b0;
      s_q.rdata <= '0;
      s_q.rresp <= RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // axi handshakes: one write and one read outstanding
  assign O_AWREADY = !s_q.aw_hold && !s_q.bvalid;
  assign O_WREADY = !s_q.w_hold && !s_q.bvalid;
  assign O_BVALID = s_q.bvalid;
  assign O_BRESP = s_q.bresp;
  assign O_ARREADY = !s_q.rvalid;
  assign O_RVALID = s_q.rvalid;
  assign O_RDATA = s_q.rdata;
  assign O_RRESP = s_q.rresp;

  // =====================================================
  // pin drive and remap
  logic [PIN_W-1:0] drive_val; // value toward pad
  logic [PIN_W-1:0] drive_en;  // pad driver on
  always_comb begin
    drive_en = ~s_q.direction & PIN_MASK;
    drive_val = s_q.latch;
    for (int unsigned k = 0; k < NUM_RP; k++) begin
      // remappable pin k is pin k+1; nonzero selector hands it to a peripheral
      if (s_q.rp_sel[k] != RP_NO_CONNECT) begin
        drive_en[k+1] = 1'b1;
        drive_val[k+1] = I_PERIPH_OUT[s_q.rp_sel[k]];
      end
    end
    // open drain: only ever drive low, release for high
    O_PIN = drive_val & ~s_q.odc;
    O_PIN_OE_N = ~(drive_en & ~(s_q.odc & drive_val));
  end

  // peripheral input selection, reserved codes route nothing
  always_comb begin
    for (int unsigned k = 0; k < NUM_IN_SEL; k++) begin
      unique case (s_q.in_sel[k])
        IN_SEL_RSV_A, IN_SEL_RSV_E, IN_SEL_RSV_F: O_PERIPH_IN[k] = 1'b0;
        default: O_PERIPH_IN[k] = pin_sync[s_q.in_sel[k]];
      endcase
    end
  end

  assign O_OPEN_DRAIN = s_q.odc;
  assign O_PULL_UP = s_q.pu;
  assign O_PULL_DOWN = s_q.pd;
  assign O_ANALOG = s_q.analog;
  assign O_IRQ = |(s_q.cn_stat & s_q.irq_mask);

  // =====================================================
  // checks
  // a watched pin changed while detection is on
  sequence s_pin_edge;
    change != '0;
  endsequence
  // an unmasked change with no mask write racing it in the same cycle
  sequence s_unmasked_edge;
    ((change & s_q.irq_mask) != '0) && !(wr_go && wr_slot == OFS_IRQ_MASK);
  endsequence

  a_change_sets_status: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    s_pin_edge |=> ((s_q.cn_stat & $past(change)) == $past(change)))
    else $error("change not recorded");
  a_irq_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    s_unmasked_edge |=> O_IRQ)
    else $error("irq not raised");
  a_alias_set_only: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (wr_go && wr_slot == OFS_DIRECTION && wr_op == ALIAS_SET)
      |=> ((s_q.direction & $past(s_q.direction)) == $past(s_q.direction)))
    else $error("set alias cleared bits");
  a_alias_clr_only: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (wr_go && wr_slot == OFS_OPEN_DRAIN && wr_op == ALIAS_CLR) |=> ((s_q.odc & $past(wr_val)) == '0))
    else $error("clear alias missed");
  a_input_no_drive: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (s_q.direction[PIN_W-1] == 1'b1) |-> O_PIN_OE_N[PIN_W-1])
    else $error("input pin driven");
  a_od_never_high: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (s_q.odc[PIN_W-1] && s_q.latch[PIN_W-1]) |-> (O_PIN_OE_N[PIN_W-1] && !O_PIN[PIN_W-1]))
    else $error("open drain drove high");
  a_reserved_in: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (s_q.in_sel[0] == IN_SEL_RSV_F) |-> !O_PERIPH_IN[0])
    else $error("reserved code routed");
  a_rp_owns_pin: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (s_q.rp_sel[0] != RP_NO_CONNECT && !s_q.odc[1]) |-> (!O_PIN_OE_N[1] && O_PIN[1] == I_PERIPH_OUT[s_q.rp_sel[0]]))
    else $error("peripheral lost pin");
  a_upper_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_RVALID |-> (O_RDATA[DATA_W-1:PIN_W] == '0))
    else $error("upper bits nonzero");
endmodule

// file: bench/gpio_pin_model.sv
// pad model for port c: resolves each pin from block drive, pulls and far side
// assumes the bench sets i_ext and i_ext_en after clock edges
`timescale 1ns/1ps
module gpio_pin_model
  import gpio_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_drive,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_oe_n,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_open_drain,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_pull_up,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_pull_down,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_ext,
  input wire logic [gpio_port_pkg::PIN_W-1:0] i_ext_en,
  output logic [gpio_port_pkg::PIN_W-1:0] o_level
);
  // =====================================================
  // pad resolution
  logic [PIN_W-1:0] last_q = '0;  // previous level, used for floating pins
  // a floating pad shows the inverse of its last level so no stale value survives
  always @(posedge i_clk) begin
    last_q <= o_level;
  end
  // block drive wins; open drain only pulls low
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!i_oe_n[i] && !(i_open_drain[i] && i_drive[i])) o_level[i] = i_drive[i];
      else if (i_ext_en[i]) o_level[i] = i_ext[i];
      else if (i_pull_up[i]) o_level[i] = 1'b1;
      else if (i_pull_down[i]) o_level[i] = 1'b0;
      else o_level[i] = ~last_q[i];
    end
  end
endmodule

// file: bench/gpio_port_with_pin_remap_test.sv
// self-checking bench for port c with pin remap, over axi4-lite
// assumes the pad model above and a single 200 mhz clock
`timescale 1ns/1ps
module gpio_port_with_pin_remap_test;
  import gpio_port_pkg::*;
  // =====================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] awaddr = '0, araddr = '0, ext = '0, ext_en = '0, pout = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awrdy, wrdy, bv, arrdy, rv, irq;
  logic [1:0] bresp, rresp, pin_in;
  logic [15:0] pin, drv, oe_n, od, pu, pd, an, m, p;
  int n_fail = 0, checks = 0;
  // register table: analog, dir, latch, od, pu, pd, cn ctl, cn en, irq mask
  localparam logic [15:0] OFS [9] = '{OFS_ANALOG_SELECT, OFS_DIRECTION, OFS_OUTPUT_LATCH, OFS_OPEN_DRAIN,
    OFS_PULL_UP, OFS_PULL_DOWN, OFS_CN_CONTROL, OFS_CN_ENABLE, OFS_IRQ_MASK};
  localparam logic [15:0] MSK [9] = '{ANALOG_MASK, PIN_MASK, PIN_MASK, PIN_MASK, PIN_MASK, PIN_MASK,
    CN_CTRL_MASK, PIN_MASK, PIN_MASK};
  localparam logic [15:0] RST [9] = '{ANALOG_RST, DIRECTION_RST & PIN_MASK, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [3:0] CODES [4] = '{4'h1, IN_SEL_RSV_A, IN_SEL_RSV_E, IN_SEL_RSV_F};
  logic [15:0] mdl [9];  // reference copy of each register
  always #2.5 clk = ~clk;
  // =====================================================
  // block and pads
  gpio_port DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(4'hf),
    .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bre),
    .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rv), .I_RREADY(rre), .I_PIN(pin), .O_PIN(drv), .O_PIN_OE_N(oe_n), .O_OPEN_DRAIN(od),
    .O_PULL_UP(pu), .O_PULL_DOWN(pd), .O_ANALOG(an), .I_PERIPH_OUT(pout), .O_PERIPH_IN(pin_in),
    .O_IRQ(irq));
  gpio_pin_model pads (.i_clk(clk), .i_drive(drv), .i_oe_n(oe_n), .i_open_drain(od), .i_pull_up(pu),
    .i_pull_down(pd), .i_ext(ext), .i_ext_en(ext_en), .o_level(pin));
  // =====================================================
  // comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] dat, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      n++;
    end while (!bv && n < 200);
    bre <= 1'b0;
    chk({bv, bresp}, {1'b1, er});
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] dat, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      n++;
    end while (!rv && n < 200);
    dat = rdata;
    rre <= 1'b0;
    chk({rv, rresp}, {1'b1, er});
  endtask
  // read one register and compare with the expectation
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  // pad controls must mirror the reference registers
  task automatic outs();
    chk(an, mdl[0]);
    chk(od, mdl[3]);
    chk(pu, mdl[4]);
    chk(pd, mdl[5]);
    chk(~oe_n & PIN_MASK, ~mdl[1] & ~(mdl[3] & mdl[2]) & PIN_MASK);
    chk(drv & ~oe_n & PIN_MASK, mdl[2] & ~mdl[1] & ~mdl[3] & PIN_MASK);
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the expected thousand or so cycles
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // =====================================================
  // main sequence
  initial begin
    void'($urandom(90));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, latch has none
    for (int i = 0; i < 8; i++) if (i != 2) rc(OFS[i], {16'h0, RST[i]});
    rc(OFS_CN_STATUS, 32'h0);
    mdl = RST;
    wr(OFS_OUTPUT_LATCH, 32'h0);
    // random base, clear, set and invert writes on each of the nine table registers
    for (int i = 0; i < 9; i++) begin
      for (int k = 0; k < 8; k++) begin
        d = $urandom;
        wr(OFS[i] + {12'h0, k[1:0], 2'b00}, d);
        case (k[1:0])
          2'd0: m = d[15:0];
          2'd1: m = mdl[i] & ~d[15:0];
          2'd2: m = mdl[i] | d[15:0];
          default: m = mdl[i] ^ d[15:0];
        endcase
        mdl[i] = m & MSK[i];
        rc(OFS[i], {16'h0, mdl[i]});
        outs();
      end
    end
    // quiet state: all inputs, far side drives every pin
    for (int i = 0; i < 9; i++) if (i != 1) wr(OFS[i], 32'h0);
    wr(OFS_DIRECTION, 32'hffff);
    ext_en <= '1;
    ext <= 16'($urandom);
    repeat (4) @(posedge clk);
    rd(OFS_CN_STATUS, d);
    rc(OFS_PIN_LEVEL, {16'h0, ext & PIN_MASK});
    // change notice on pin 12 only, unmasked then masked
    wr(OFS_CN_CONTROL, 32'h8000);
    wr(OFS_CN_ENABLE, 32'h1000);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_IRQ_MASK, j ? 32'h0 : 32'h1000);
      ext <= ext ^ 16'h3000;
      repeat (6) @(posedge clk);
      chk(irq, j ? 1'b0 : 1'b1);
      rc(OFS_CN_STATUS, 32'h1000);
      rc(OFS_CN_STATUS, 32'h0);
      chk(irq, 1'b0);
    end
    // detection off: no status
    wr(OFS_CN_CONTROL, 32'h0);
    ext <= ext ^ 16'h1000;
    repeat (6) @(posedge clk);
    rc(OFS_CN_STATUS, 32'h0);
    // output remap on pins 1 and 2, latch set opposite to prove ownership
    wr(OFS_DIRECTION + 16'h4, 32'h6);
    for (int c = 0; c < 16; c++) begin
      p = 16'($urandom);
      pout <= p;
      wr(OFS_OUTPUT_LATCH, {16'h0, ~p});
      wr(OFS_RP_SEL0, c);
      wr(OFS_RP_SEL1, 15 - c);
      chk(drv[1], c == 0 ? !p[1] : p[c]);
      chk(drv[2], c == 15 ? !p[2] : p[15-c]);
    end
    // input remap: reserved codes route nothing
    wr(OFS_RP_SEL0, 32'h0);
    wr(OFS_RP_SEL1, 32'h0);
    wr(OFS_DIRECTION, 32'hffff);
    for (int v = 0; v < 2; v++) begin
      ext <= v ? 16'hffff : 16'h0;
      for (int c = 0; c < 4; c++) begin
        wr(OFS_IN_SEL0, {28'h0, CODES[c]});
        wr(OFS_IN_SEL1, {28'h0, CODES[c]});
        repeat (4) @(posedge clk);
        chk(pin_in, (c == 0 && v == 1) ? 2'b11 : 2'b00);
      end
    end
    // unmapped place answers with an error and zero data
    wr(16'h6300, 32'h1, RESP_SLVERR);
    rd(16'h6300, d, RESP_SLVERR);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule
